//--- design/ortap_top.sv
// Orientation pins, tap interrupt and power-down control
//
// Notes on behaviour
// - Portrait pin high only for portrait orientation
// - Landscape pin high only for landscape orientation
// - Sign pin tells the two opposite directions
// - Steady attitude classified into six orientations
// - Power-down pin low runs, high sleeps
// - Measurement chain off while power-down high
// - Outputs invalid for turn-on time after wake
// - Tap raises interrupt when tap enabled
// - Double tap needs second tap within window
`timescale 1ns/1ps
`default_nettype none
module ortap_top
  import ortap_pkg::*;
#(
  parameter int TON_CYCLES    = ortap_pkg::TON_CYC,
  parameter int TICK_CYCLES   = ortap_pkg::TICK_CYC,
  parameter int STEADY_CYCLES = ortap_pkg::STEADY_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        power_down_input,
  input  wire logic [1:0]                  axis_dom,
  input  wire logic                        axis_neg,
  input  wire logic                        tap_hit,
  input  wire logic [ortap_pkg::ADDR_W-1:0] addr,
  input  wire logic [ortap_pkg::DATA_W-1:0] wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [ortap_pkg::DATA_W-1:0] rd_data,
  output logic                             portrait_indicator,
  output logic                             landscape_indicator,
  output logic                             sign_output,
  output logic                             orient_valid,
  output logic                             meas_chain_en,
  output logic                             tap_int,
  output logic                             irq
);
  import ortap_pkg::*;

  typedef struct packed {
    ortap_pwr_t         pwr;
    logic [WCNT_W-1:0]  wcnt;
    logic [2:0]         cand;
    logic [7:0]         scnt;
    logic [2:0]         orient;
    logic               ovalid;
    logic               pc;
    logic               lc;
    logic               sgn;
    logic               chain;
    ortap_tap_t         tstate;
    logic [WIN_W-1:0]   tcnt;
    logic [TICK_W-1:0]  tick;
    logic               tint;
    logic               tap_en;
    logic               dbl_en;
    logic [WIN_W-1:0]   win;
    logic [NSTAT-1:0]   stat;
    logic [NSTAT-1:0]   mask;
    logic               irq;
    logic [DATA_W-1:0]  rdata;
  } ortap_state_t;

  ortap_state_t q, d;
  logic         pd_s;
  logic [2:0]   code_in;
  logic [NSTAT-1:0] ev;
  logic         tickp;

  // Power-down pin arrives asynchronously, so it is synchronised
  ortap_sync #(
    .W (1)
  ) u_pd_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (power_down_input),
    .dout    (pd_s)
  );

  assign code_in = {axis_dom, axis_neg};

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    ev = '0;
    tickp = 1'b0;
    d.tint = 1'b0;
    d.rdata = '0;
    if (pd_s) begin
      d.pwr = PWR_OFF;
      d.chain = 1'b0;
      d.ovalid = 1'b0;
      d.pc = 1'b0;
      d.lc = 1'b0;
      d.sgn = 1'b0;
      d.scnt = '0;
      d.tstate = TAP_IDLE;
      d.tick = '0;
    end else begin
      unique case (q.pwr)
        PWR_OFF: begin
          d.pwr = PWR_WARM;
          d.wcnt = '0;
          d.chain = 1'b1;
        end
        PWR_WARM: begin
          if (q.wcnt == WCNT_W'(TON_CYCLES - 1)) begin
            d.pwr = PWR_RUN;
            ev[STAT_RDY] = 1'b1;
          end else begin
            d.wcnt = q.wcnt + WCNT_W'(1);
          end
        end
        PWR_RUN: begin
          // commit only after a steady run
          if (axis_dom == AX_NONE) begin
            d.scnt = '0;
          end else if (code_in != q.cand) begin
            d.cand = code_in;
            d.scnt = '0;
          end else if (q.scnt != 8'(STEADY_CYCLES - 1)) begin
            d.scnt = q.scnt + 8'h01;
          end else begin
            if (!q.ovalid || q.orient != q.cand) begin
              ev[STAT_ORI] = 1'b1;
            end
            d.orient = q.cand;
            d.ovalid = 1'b1;
            // sign from direction, face keeps both low
            // all three pins change on one edge
            {d.pc, d.lc, d.sgn} = ortap_pins(q.cand);
          end
          // Millisecond tick for the double-tap window
          if (q.tick == TICK_W'(TICK_CYCLES - 1)) begin
            d.tick = '0;
            tickp = 1'b1;
          end else begin
            d.tick = q.tick + TICK_W'(1);
          end
          unique case (q.tstate)
            TAP_IDLE: begin
              if (tap_hit && q.tap_en) begin
                if (q.dbl_en) begin
                  d.tstate = TAP_WAIT;
                  d.tcnt = q.win;
                  d.tick = '0;
                end else begin
                  d.tint = 1'b1;
                  ev[STAT_TAP] = 1'b1;
                end
              end
            end
            // second tap only inside the window
            TAP_WAIT: begin
              if (tap_hit) begin
                d.tint = 1'b1;
                ev[STAT_TAP] = 1'b1;
                d.tstate = TAP_IDLE;
              end else if (!q.tap_en || !q.dbl_en) begin
                d.tstate = TAP_IDLE;
              end else if (tickp) begin
                if (q.tcnt <= 8'h01) begin
                  d.tstate = TAP_IDLE;
                end else begin
                  d.tcnt = q.tcnt - 8'h01;
                end
              end
            end
          endcase
        end
        default: begin
          d.pwr = PWR_OFF;
        end
      endcase
    end
    // Register writes; a status event beats a same-cycle clear
    if (wr_en) begin
      unique case (addr)
        CTRL_OFS: begin
          d.tap_en = wr_data[CTRL_TAP_EN];
          d.dbl_en = wr_data[CTRL_DBL_EN];
          d.win = wr_data[CTRL_WIN_LSB +: WIN_W];
        end
        STAT_OFS: d.stat = q.stat & ~wr_data[NSTAT-1:0];
        MASK_OFS: d.mask = wr_data[NSTAT-1:0];
        default: ;
      endcase
    end
    d.stat = d.stat | ev;
    d.irq = |(d.stat & d.mask);
    // Read data stands the cycle after the strobe only
    if (rd_en) begin
      unique case (addr)
        CTRL_OFS: begin
          d.rdata[CTRL_TAP_EN] = q.tap_en;
          d.rdata[CTRL_DBL_EN] = q.dbl_en;
          d.rdata[CTRL_WIN_LSB +: WIN_W] = q.win;
        end
        STAT_OFS: d.rdata[NSTAT-1:0] = q.stat;
        MASK_OFS: d.rdata[NSTAT-1:0] = q.mask;
        STATE_OFS: begin
          d.rdata[2:0] = q.orient;
          d.rdata[3] = q.ovalid;
          d.rdata[4] = pd_s;
          d.rdata[5] = q.pwr == PWR_RUN;
          d.rdata[6] = q.tstate == TAP_WAIT;
        end
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.pwr <= PWR_OFF;
      q.tstate <= TAP_IDLE;
      q.tap_en <= TAP_EN_RST;
      q.dbl_en <= DBL_EN_RST;
      q.win <= WIN_RST;
      q.mask <= MASK_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data = q.rdata;
  assign portrait_indicator = q.pc;
  assign landscape_indicator = q.lc;
  assign sign_output = q.sgn;
  assign orient_valid = q.ovalid;
  assign meas_chain_en = q.chain;
  assign tap_int = q.tint;
  assign irq = q.irq;

  // Helper: cycles awake since the pin fell, saturating
  logic [WCNT_W-1:0] awake_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awake_q <= '0;
    end else if (pd_s) begin
      awake_q <= '0;
    end else if (awake_q != '1) begin
      awake_q <= awake_q + WCNT_W'(1);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_first_tap;
    q.tstate == TAP_IDLE && tap_hit && q.tap_en && q.dbl_en &&
      q.pwr == PWR_RUN && !pd_s;
  endsequence

  sequence s_armed;
    q.tstate == TAP_WAIT && !tap_int;
  endsequence

  sequence s_window_cut;
    q.tstate == TAP_WAIT && !tap_hit && !pd_s && !(q.tap_en && q.dbl_en);
  endsequence

  a_portrait_pin: assert property (
    portrait_indicator |-> orient_valid && q.orient[2:1] == AX_PORT)
    else $error("portrait pin high without portrait");
  a_landscape_pin: assert property (
    landscape_indicator |-> orient_valid && q.orient[2:1] == AX_LAND)
    else $error("landscape pin high without landscape");
  a_sign_dir: assert property (
    orient_valid |-> sign_output == ~q.orient[0])
    else $error("sign pin disagrees with direction");
  a_steady_commit: assert property (
    $rose(orient_valid) || $changed(q.orient) |->
      $past(q.scnt) == 8'(STEADY_CYCLES - 1) && $past(q.pwr) == PWR_RUN)
    else $error("orientation committed before steady");
  a_chain_off: assert property (
    pd_s |=> !meas_chain_en && !orient_valid)
    else $error("chain still on in power-down");
  a_turn_on: assert property (
    $rose(orient_valid) |-> awake_q > WCNT_W'(TON_CYCLES))
    else $error("outputs valid before turn-on time");
  a_single_tap: assert property (
    q.pwr == PWR_RUN && !pd_s && q.tap_en && !q.dbl_en && tap_hit
      |=> tap_int)
    else $error("tap not reported");
  // first tap of a pair only arms
  a_double_arm: assert property (
    s_first_tap |=> s_armed)
    else $error("first of double tap not armed");
  // double mode interrupt needs armed window
  a_double_only: assert property (
    tap_int && q.dbl_en && $past(q.dbl_en) |->
      $past(q.tstate) == TAP_WAIT)
    else $error("double tap interrupt without window");
  // face attitude keeps both pins low
  a_face_low: assert property (
    orient_valid && q.orient[2:1] == AX_FACE |->
      !portrait_indicator && !landscape_indicator)
    else $error("face attitude drives a position pin");
  // at most one position pin high
  a_pins_onehot: assert property (
    !(portrait_indicator && landscape_indicator))
    else $error("both position pins high");
  a_chain_awake: assert property (
    !pd_s && q.pwr != PWR_OFF |-> meas_chain_en)
    else $error("chain off while awake");
  a_tap_asleep: assert property (
    pd_s |=> !tap_int)
    else $error("tap reported in power-down");
  // all three pins low while asleep
  a_pins_asleep: assert property (
    pd_s |=> !portrait_indicator && !landscape_indicator && !sign_output)
    else $error("orientation pins driven in power-down");
  a_warm_invalid: assert property (
    q.pwr != PWR_RUN |-> !orient_valid)
    else $error("outputs valid before running");
  a_tap_blocked: assert property (
    q.tstate == TAP_IDLE && !q.tap_en |=> !tap_int)
    else $error("tap reported while disabled");
  // clearing an enable closes the window
  a_window_cut: assert property (
    s_window_cut |=> q.tstate == TAP_IDLE && !tap_int)
    else $error("double tap window not closed");
endmodule
`default_nettype wire

//--- design/ortap_pkg.sv
// Shared constants and types for the orientation and tap pin block
package ortap_pkg;
  // Register offsets on the plain register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] CTRL_OFS  = 4'h0;
  localparam logic [3:0] STAT_OFS  = 4'h4;
  localparam logic [3:0] MASK_OFS  = 4'h8;
  localparam logic [3:0] STATE_OFS = 4'hC;
  // Control field positions and reset value
  localparam int CTRL_TAP_EN = 0;
  localparam int CTRL_DBL_EN = 1;
  localparam int CTRL_WIN_LSB = 8;
  localparam int WIN_W = 8;
  localparam logic [7:0] WIN_RST = 8'h0A;
  localparam logic TAP_EN_RST = 1'b1;
  localparam logic DBL_EN_RST = 1'b0;
  // Status and mask bit positions
  localparam int NSTAT = 3;
  localparam int STAT_TAP = 0;
  localparam int STAT_ORI = 1;
  localparam int STAT_RDY = 2;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Dominant axis codes from the sensing front end
  localparam logic [1:0] AX_NONE = 2'h0;
  localparam logic [1:0] AX_LAND = 2'h1;
  localparam logic [1:0] AX_PORT = 2'h2;
  localparam logic [1:0] AX_FACE = 2'h3;
  // Timing: clock rate, turn-on time, tap window tick, steadiness
  localparam int CLK_HZ = 100_000_000;
  localparam int TON_MS = 30;
  localparam int TON_CYC = TON_MS * (CLK_HZ / 1000);
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam int STEADY_CYC = 16;
  localparam int WCNT_W = 22;
  localparam int TICK_W = 17;

  typedef enum logic [1:0] {PWR_OFF, PWR_WARM, PWR_RUN} ortap_pwr_t;
  typedef enum logic {TAP_IDLE, TAP_WAIT} ortap_tap_t;

  // Pin pattern {portrait, landscape, sign} for an orientation code
  function automatic logic [2:0] ortap_pins(input logic [2:0] code);
    ortap_pins = {code[2:1] == AX_PORT, code[2:1] == AX_LAND, ~code[0]};
  endfunction
endpackage

//--- design/ortap_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ortap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ortap_sync_t;

  ortap_sync_t q, d;

  // First stage feeds only the second
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule
`default_nettype wire

//--- tb/ortap_host_model.sv
// Host model reading the orientation pins and counting tap interrupts
`timescale 1ns/1ps
`default_nettype none
module ortap_host_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       pd_req,
  input  wire logic       portrait_indicator,
  input  wire logic       landscape_indicator,
  input  wire logic       sign_output,
  input  wire logic       orient_valid,
  input  wire logic       tap_int,
  output logic            power_down_input,
  output logic      [2:0] host_code,
  output logic      [7:0] host_taps
);
  logic [2:0] pins_q;

  assign power_down_input = pd_req;

  // stable sample only, ignored while warming up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_q    <= 3'h0;
      host_code <= 3'h0;
      host_taps <= 8'h00;
    end else begin
      pins_q <= {portrait_indicator, landscape_indicator, sign_output};
      if (orient_valid && pins_q == {portrait_indicator,
          landscape_indicator, sign_output}) begin
        host_code <= pins_q;
      end
      if (tap_int) begin
        host_taps <= host_taps + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/orientation_tap_pin_outputs_test.sv
// Self-checking bench for the orientation and tap pin block
`timescale 1ns/1ps
`default_nettype none
module orientation_tap_pin_outputs_test;
  import ortap_pkg::*;
  localparam int TON = 20;
  localparam int TCK = 4;
  localparam int STD = 4;
  logic        clk_sys = 1'b0, rst = 1'b1, pd_req = 1'b0, pd;
  logic [1:0]  axis_dom = 2'h0;
  logic        axis_neg = 1'b0, tap_hit = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wr_data = 32'h0, rd_data, v;
  logic        por, lan, sgn, valid, chain, tap_int, irq;
  logic [2:0]  hcode;
  logic [7:0]  htaps, t0;
  int          fails = 0, comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  ortap_top #(.TON_CYCLES(TON), .TICK_CYCLES(TCK), .STEADY_CYCLES(STD))
  u_ortap_top (.clk_sys(clk_sys), .rst(rst), .power_down_input(pd),
    .axis_dom(axis_dom), .axis_neg(axis_neg), .tap_hit(tap_hit),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .portrait_indicator(por),
    .landscape_indicator(lan), .sign_output(sgn), .orient_valid(valid),
    .meas_chain_en(chain), .tap_int(tap_int), .irq(irq));

  ortap_host_model u_ortap_host_model (.clk_sys(clk_sys), .rst(rst),
    .pd_req(pd_req), .portrait_indicator(por), .landscape_indicator(lan),
    .sign_output(sgn), .orient_valid(valid), .tap_int(tap_int),
    .power_down_input(pd), .host_code(hcode), .host_taps(htaps));

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic tap(input int gap);
    @(posedge clk_sys);
    tap_hit <= 1'b1;
    @(posedge clk_sys);
    tap_hit <= 1'b0;
    repeat (gap) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_valid();
    for (int i = 0; i < 300 && valid !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (valid !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t orientation never became valid", $time);
      finish_test();
    end
  endtask

  // Pins expected from the steady code held at the front end
  task automatic chk_pins(input logic [1:0] d, input logic n);
    chk({29'h0, por, lan, sgn}, {29'h0, d == 2'h2, d == 2'h1, ~n});
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(CTRL_OFS, v); chk(v, 32'h0000_0A01);
    rd(MASK_OFS, v); chk(v, 32'h0);
    rd(4'h2, v); chk(v, 32'h0);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(MASK_OFS, v); chk(v, 32'h0);
    // Six orientations, face positions included
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      axis_dom <= 2'(k / 2 + 1);
      axis_neg <= k[0];
      if (k == 0) wait_valid();
      repeat (STD + 3) @(posedge clk_sys);
      #1 chk_pins(2'(k / 2 + 1), k[0]);
      chk({29'h0, hcode}, {29'h0, k / 2 == 1, k / 2 == 0, ~k[0]});
      rd(STATE_OFS, v); chk(v & 32'h7, 32'(k + 2));
    end
    // No dominant axis keeps the last pins
    @(posedge clk_sys);
    axis_dom <= 2'h0;
    repeat (STD + 3) @(posedge clk_sys);
    #1 chk_pins(2'h3, 1'b1);
    // Tap interrupt, masked and unmasked
    wr(STAT_OFS, 32'h7);
    wr(MASK_OFS, 32'h1);
    t0 = htaps;
    tap(2); chk(htaps, t0 + 8'h01);
    chk(irq, 1'b1);
    rd(STAT_OFS, v); chk(v, 32'h1);
    wr(STAT_OFS, 32'h1);
    #1 chk(irq, 1'b0);
    wr(MASK_OFS, 32'h0);
    tap(2); chk(irq, 1'b0);
    rd(STAT_OFS, v); chk(v, 32'h1);
    wr(STAT_OFS, 32'h1);
    // Double tap inside the window, then one left to expire
    wr(CTRL_OFS, 32'h0000_0A03);
    t0 = htaps;
    tap(4); chk(htaps, t0);
    tap(2); chk(htaps, t0 + 8'h01);
    tap(50); tap(2); chk(htaps, t0 + 8'h01);
    rd(STATE_OFS, v); chk(v & 32'h40, 32'h40);
    wr(CTRL_OFS, 32'h0);
    rd(STATE_OFS, v); chk(v & 32'h40, 32'h0);
    tap(2); chk(htaps, t0 + 8'h01);
    wr(CTRL_OFS, 32'h0000_0A01);
    // Power down, then wake with the turn-on delay
    @(posedge clk_sys);
    axis_dom <= 2'h1;
    axis_neg <= 1'b0;
    pd_req   <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 chk({28'h0, chain, por, lan, valid}, 32'h0);
    rd(STATE_OFS, v); chk(v & 32'h78, 32'h10);
    tap(2); chk(htaps, t0 + 8'h01);
    @(posedge clk_sys);
    pd_req <= 1'b0;
    for (int i = 0; i < TON; i++) begin
      @(posedge clk_sys);
      #1;
      if (valid !== 1'b0) begin
        fails++;
        $display("[FAIL] %0t valid during turn-on", $time);
      end
    end
    chk(valid, 1'b0);
    wait_valid();
    #1 chk_pins(2'h1, 1'b0);
    chk(chain, 1'b1);
    rd(STAT_OFS, v); chk(v, 32'h7);
    rd(STATE_OFS, v); chk(v, 32'h2A);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
